/* shared/pmbid_pkg.sv */
package pmbid_pkg;
  // command codes of the identity bank
  localparam logic [7:0] CMD_MODEL = 8'h9A;
  localparam logic [7:0] CMD_REVISION = 8'h9B;
  localparam logic [7:0] CMD_SERIAL = 8'h9E;
  localparam logic [7:0] CMD_CHIP_ID = 8'hAD;
  localparam logic [7:0] CMD_CHIP_REV = 8'hAE;
  // block lengths in bytes
  localparam logic [2:0] LEN_STORE = 3'h3;
  localparam logic [2:0] LEN_CHIP_ID = 3'h6;
  localparam logic [2:0] LEN_CHIP_REV = 3'h2;
  // fault bit positions
  localparam int CML_IVC_BIT = 7;
  localparam int STATUS_BYTE_CML_BIT = 1;
  // chip revision field positions
  localparam int REV_MAJOR_LSB = 12;
  localparam int REV_MINOR_LSB = 8;
  // reset values before nvm reload
  localparam logic [23:0] STORE_RESET = 24'h000000;
  // arbitrary neutral identity values
  localparam logic [47:0] CHIP_ID_DEFAULT = 48'h000000000001;
  localparam logic [15:0] CHIP_REV_DEFAULT = 16'h1000;
endpackage : pmbid_pkg

/* src/pmbid_registers.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: 9Ah is a 24-bit model store, three-byte block access, nvm backed.
// R2: 9Bh is a 24-bit revision store, three-byte block access, nvm backed.
// R3: 9Eh is a 24-bit serial store, three-byte block access, nvm backed.
// R4: the serial value is part of the nvm image that feeds the checksum.
// R5: ADh returns a fixed 48-bit chip identity, six bytes, byte 0 first.
// R6: AEh returns a 16-bit chip revision: major 15:12, minor 11:8, sub 7:0.
// R7: a write to a read-only command sets the cml and invalid-command flags.
// R8: after that fault the host is notified by the bus fault alert.
// R9: the host normally writes the three stores once, at manufacture.
// R10: a write to chip identity or revision leaves the values unchanged.
module pmbid_registers #(
  parameter logic [47:0] CHIP_ID = pmbid_pkg::CHIP_ID_DEFAULT,
  parameter logic [15:0] CHIP_REV = pmbid_pkg::CHIP_REV_DEFAULT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] cmd_code,
  input wire logic wr_byte_valid,
  input wire logic [7:0] wr_byte,
  input wire logic wr_end,
  input wire logic rd_byte_req,
  input wire logic rd_start,
  input wire logic nvm_load,
  input wire logic [71:0] nvm_load_data,
  input wire logic fault_clear,
  output logic [7:0] rd_byte,
  output logic [2:0] rd_len,
  output logic rd_valid,
  output logic [71:0] nvm_image,
  output logic cml_ivc_flag,
  output logic status_cml_flag,
  output logic alert_n
);
  logic [23:0] model_info_store_reg;
  logic [23:0] revision_info_store_reg;
  logic [23:0] serial_number_store_reg;
  logic [23:0] shift_reg;
  logic [1:0] wcnt_reg;
  logic [2:0] rptr_reg;
  logic [7:0] rd_byte_reg;
  logic [2:0] rd_len_reg;
  logic rd_valid_reg;
  logic ivc_reg;
  logic cml_reg;
  logic alert_n_reg;
  logic [71:0] nvm_image_reg;
  logic [47:0] rd_word;
  logic [2:0] rd_len_next;
  logic is_ro;
  logic is_model;
  logic is_rev;
  logic is_serial;
  logic commit;
  logic ro_write;
  logic [23:0] shift_next;

  // command decode
  assign is_model = cmd_code == pmbid_pkg::CMD_MODEL;
  assign is_rev = cmd_code == pmbid_pkg::CMD_REVISION;
  assign is_serial = cmd_code == pmbid_pkg::CMD_SERIAL;
  assign is_ro = cmd_code == pmbid_pkg::CMD_CHIP_ID ||
                 cmd_code == pmbid_pkg::CMD_CHIP_REV;
  // short blocks and blocks of four to six bytes are dropped; three bytes commit, and so do seven, as the count restarts
  assign commit = wr_end && wcnt_reg == 2'h3 &&
                  (is_model || is_rev || is_serial);
  assign ro_write = is_ro && wr_byte_valid; // [R7]
  assign shift_next = {wr_byte, shift_reg[23:8]}; // byte 0 arrives first
  // read word, byte 0 in low bits
  assign rd_word = is_model ? {24'h000000, model_info_store_reg} : // [R1]
                   is_rev ? {24'h000000, revision_info_store_reg} : // [R2]
                   is_serial ? {24'h000000, serial_number_store_reg} : // [R3]
                   cmd_code == pmbid_pkg::CMD_CHIP_ID ? CHIP_ID : // [R5]
                   cmd_code == pmbid_pkg::CMD_CHIP_REV ?
                     {32'h00000000, CHIP_REV} : 48'h000000000000; // [R6]
  assign rd_len_next = (is_model || is_rev || is_serial) ?
                       pmbid_pkg::LEN_STORE :
                       cmd_code == pmbid_pkg::CMD_CHIP_ID ?
                       pmbid_pkg::LEN_CHIP_ID :
                       cmd_code == pmbid_pkg::CMD_CHIP_REV ?
                       pmbid_pkg::LEN_CHIP_REV : 3'h0;

  // write byte collection
  always_ff @(posedge mclk)
  begin
    if (sys_rst || wr_end)
    begin
      wcnt_reg <= 2'h0;
      shift_reg <= 24'h000000;
    end
    else if (wr_byte_valid && !is_ro && wcnt_reg != 2'h3)
    begin
      wcnt_reg <= wcnt_reg + 2'h1;
      shift_reg <= shift_next;
    end
    else if (wr_byte_valid && !is_ro)
      wcnt_reg <= 2'h0; // a fourth byte restarts the count
  end

  // stores: nvm reload or committed block write
  // chip id and rev are constants so writes cannot touch them [R10]
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      model_info_store_reg <= pmbid_pkg::STORE_RESET;
      revision_info_store_reg <= pmbid_pkg::STORE_RESET;
      serial_number_store_reg <= pmbid_pkg::STORE_RESET;
    end
    else if (nvm_load)
    begin
      model_info_store_reg <= nvm_load_data[23:0]; // [R1]
      revision_info_store_reg <= nvm_load_data[47:24]; // [R2]
      serial_number_store_reg <= nvm_load_data[71:48]; // [R3]
    end
    else if (commit)
    begin
      if (is_model)
        model_info_store_reg <= shift_reg; // [R1]
      if (is_rev)
        revision_info_store_reg <= shift_reg; // [R2]
      if (is_serial)
        serial_number_store_reg <= shift_reg; // [R3]
    end
  end

  // image fed to nvm and its checksum, serial included
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      nvm_image_reg <= 72'h000000000000000000;
    else
      nvm_image_reg <= {serial_number_store_reg, revision_info_store_reg,
                        model_info_store_reg}; // [R4]
  end

  // read byte pointer, restarted per transaction
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rptr_reg <= 3'h0;
      rd_byte_reg <= 8'h00;
      rd_len_reg <= 3'h0;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= rd_byte_req;
      if (rd_start)
      begin
        rptr_reg <= 3'h0;
        rd_len_reg <= rd_len_next;
      end
      else if (rd_byte_req)
      begin
        rd_byte_reg <= rd_word[{rptr_reg, 3'b000} +: 8]; // [R5]
        rptr_reg <= rptr_reg + 3'h1;
      end
    end
  end

  // fault flags: set wins over clear, alert follows the flag
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ivc_reg <= 1'b0;
      cml_reg <= 1'b0;
      alert_n_reg <= 1'b1;
    end
    else
    begin
      ivc_reg <= ro_write | (ivc_reg & ~fault_clear); // [R7]
      cml_reg <= ro_write | (cml_reg & ~fault_clear); // [R7]
      alert_n_reg <= ~(ro_write | (ivc_reg & ~fault_clear)); // [R8]
    end
  end

  assign rd_byte = rd_byte_reg;
  assign rd_len = rd_len_reg;
  assign rd_valid = rd_valid_reg;
  assign nvm_image = nvm_image_reg;
  assign cml_ivc_flag = ivc_reg;
  assign status_cml_flag = cml_reg;
  assign alert_n = alert_n_reg;

  property p_ivc_set;
    @(posedge mclk) disable iff (sys_rst) ro_write |=> ivc_reg && cml_reg;
  endproperty
  a_ivc_set: assert property (p_ivc_set) else $error("ivc not set"); // [R7]

  property p_alert;
    @(posedge mclk) disable iff (sys_rst) ivc_reg |-> !alert_n_reg;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing"); // [R8]

  property p_ro_len;
    @(posedge mclk) disable iff (sys_rst)
      rd_start && cmd_code == pmbid_pkg::CMD_CHIP_ID |=> rd_len_reg == 3'h6;
  endproperty
  a_ro_len: assert property (p_ro_len) else $error("id length"); // [R5]

  property p_rev_len;
    @(posedge mclk) disable iff (sys_rst)
      rd_start && cmd_code == pmbid_pkg::CMD_CHIP_REV |=> rd_len_reg == 3'h2;
  endproperty
  a_rev_len: assert property (p_rev_len) else $error("rev length"); // [R6]

  property p_model_commit;
    @(posedge mclk) disable iff (sys_rst)
      commit && is_model && !nvm_load |=>
        model_info_store_reg == $past(shift_reg);
  endproperty
  a_model_commit: assert property (p_model_commit) // [R1]
    else $error("model");

  property p_rev_commit;
    @(posedge mclk) disable iff (sys_rst)
      commit && is_rev && !nvm_load |=>
        revision_info_store_reg == $past(shift_reg);
  endproperty
  a_rev_commit: assert property (p_rev_commit) else $error("rev"); // [R2]

  property p_serial_img;
    @(posedge mclk) disable iff (sys_rst)
      commit && is_serial && !nvm_load |=> ##1
        nvm_image_reg[71:48] == $past(shift_reg, 2);
  endproperty
  a_serial_img: assert property (p_serial_img) else $error("serial"); // [R3]

  property p_ro_stable;
    @(posedge mclk) disable iff (sys_rst)
      ro_write |=> $stable(model_info_store_reg) || $past(nvm_load);
  endproperty
  a_ro_stable: assert property (p_ro_stable) else $error("ro write"); // [R10]
endmodule : pmbid_registers
`default_nettype wire

/* verif/pmbid_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// bus host: moves its lines 1 ns after each rising edge
module pmbid_host_model (
  input wire logic mclk,
  input wire logic [7:0] rd_byte,
  input wire logic [2:0] rd_len,
  input wire logic rd_valid,
  output logic [7:0] cmd_code,
  output logic wr_byte_valid,
  output logic [7:0] wr_byte,
  output logic wr_end,
  output logic rd_byte_req,
  output logic rd_start
);
  // idle levels before the first transfer
  initial
  begin
    cmd_code = 8'h00;
    wr_byte_valid = 1'b0;
    wr_byte = 8'h00;
    wr_end = 1'b0;
    rd_byte_req = 1'b0;
    rd_start = 1'b0;
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  // block write, lowest byte first; data flips once no longer valid
  task automatic wr_blk(input logic [7:0] cmd, input logic [47:0] d,
    input int cnt);
    cmd_code = cmd;
    for (int i = 0; i < cnt; i++)
    begin
      wr_byte_valid = 1'b1;
      wr_byte = d[8*i +: 8];
      step();
    end
    wr_byte_valid = 1'b0;
    wr_byte = ~wr_byte;
    wr_end = 1'b1;
    step();
    wr_end = 1'b0;
  endtask : wr_blk

  // block read; a byte without its valid strobe is kept unknown
  task automatic rd_blk(input logic [7:0] cmd, output logic [47:0] q,
    output logic [2:0] n);
    q = 48'h0;
    cmd_code = cmd;
    rd_start = 1'b1;
    step();
    rd_start = 1'b0;
    n = rd_len;
    rd_byte_req = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      step();
      q[8*i +: 8] = (rd_valid === 1'b1) ? rd_byte : 8'hXX;
    end
    rd_byte_req = 1'b0;
  endtask : rd_blk
endmodule : pmbid_host_model
`default_nettype wire

/* verif/test_pmbus_identity_registers.sv */
`timescale 1ns/10ps
`default_nettype none
module test_pmbus_identity_registers;
  typedef struct {logic [7:0] cmd; logic [47:0] wd; logic [47:0] rd;
    logic [2:0] len; logic flt;} pmbid_row_t;
  localparam logic [47:0] ID_VAL = 48'h0102030A0B0C; // arbitrary value
  localparam logic [15:0] REV_VAL = {4'h2, 4'hA, 8'h5C}; // arbitrary value
  logic mclk, sys_rst, nvm_load, fault_clear, wr_byte_valid, wr_end;
  logic rd_byte_req, rd_start, rd_valid, cml_ivc_flag, status_cml_flag;
  logic alert_n;
  logic [7:0] cmd_code, wr_byte, rd_byte;
  logic [2:0] rd_len, n;
  logic [71:0] nvm_load_data, nvm_image;
  logic [47:0] q;
  int err_count = 0;
  int check_count = 0;
  pmbid_row_t rows [5];
  pmbid_host_model host (.mclk(mclk), .rd_byte(rd_byte), .rd_len(rd_len),
    .rd_valid(rd_valid), .cmd_code(cmd_code), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .wr_end(wr_end), .rd_byte_req(rd_byte_req),
    .rd_start(rd_start));
  pmbid_registers #(.CHIP_ID(ID_VAL), .CHIP_REV(REV_VAL)) uut (.mclk(mclk),
    .sys_rst(sys_rst), .cmd_code(cmd_code), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .wr_end(wr_end), .rd_byte_req(rd_byte_req),
    .rd_start(rd_start), .nvm_load(nvm_load), .nvm_load_data(nvm_load_data),
    .fault_clear(fault_clear), .rd_byte(rd_byte), .rd_len(rd_len),
    .rd_valid(rd_valid), .nvm_image(nvm_image), .cml_ivc_flag(cml_ivc_flag),
    .status_cml_flag(status_cml_flag), .alert_n(alert_n));
  // 50 MHz clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle strobe on a side input
  task automatic pulse(ref logic s);
    s = 1'b1;
    host.step();
    s = 1'b0;
  endtask : pulse

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // guard against a hang, far beyond the hundred or so cycles needed
  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end

  // reset-value read first, then rows, nvm image, short block, reload, long block, flag and reset cases
  initial
  begin
    sys_rst = 1'b1;
    nvm_load = 1'b0;
    fault_clear = 1'b0;
    nvm_load_data = 72'h0;
    rows[0] = '{pmbid_pkg::CMD_MODEL, 48'h1E2D3C, 48'h1E2D3C, 3'h3, 1'b0};
    rows[1] = '{pmbid_pkg::CMD_REVISION, 48'hA55A01, 48'hA55A01, 3'h3, 1'b0};
    rows[2] = '{pmbid_pkg::CMD_SERIAL, 48'h00FF80, 48'h00FF80, 3'h3, 1'b0};
    rows[3] = '{pmbid_pkg::CMD_CHIP_ID, 48'hFFFFFF, ID_VAL, 3'h6, 1'b1};
    rows[4] = '{pmbid_pkg::CMD_CHIP_REV, 48'h0, {32'h0, REV_VAL}, 3'h2, 1'b1};
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    host.rd_blk(pmbid_pkg::CMD_SERIAL, q, n);
    chk(q, 48'h0);
    foreach (rows[k])
    begin
      pulse(fault_clear);
      host.wr_blk(rows[k].cmd, rows[k].wd, 3);
      host.rd_blk(rows[k].cmd, q, n);
      chk(q, rows[k].rd);
      chk(48'({n, cml_ivc_flag, status_cml_flag, alert_n}),
        48'({rows[k].len, rows[k].flt, rows[k].flt, ~rows[k].flt}));
    end
    chk(48'(nvm_image[71:48]), 48'h00FF80);
    chk(nvm_image[47:0], 48'hA55A011E2D3C);
    host.wr_blk(pmbid_pkg::CMD_SERIAL, 48'h123456, 2);
    host.rd_blk(pmbid_pkg::CMD_SERIAL, q, n);
    chk(q, 48'h00FF80);
    nvm_load_data = 72'hC0FFEE_5A5A5A_0B0C0D;
    pulse(nvm_load);
    host.rd_blk(pmbid_pkg::CMD_MODEL, q, n);
    chk(q, 48'h0B0C0D);
    host.rd_blk(pmbid_pkg::CMD_SERIAL, q, n);
    chk(q, 48'hC0FFEE);
    host.rd_blk(pmbid_pkg::CMD_REVISION, q, n);
    chk(q, 48'h5A5A5A);
    // a fourth byte discards the whole block
    host.wr_blk(pmbid_pkg::CMD_MODEL, 48'h11223344, 4);
    host.rd_blk(pmbid_pkg::CMD_MODEL, q, n);
    chk(q, 48'h0B0C0D);
    // clear alone drops both flags and the alert
    pulse(fault_clear);
    chk(48'({cml_ivc_flag, status_cml_flag, alert_n}), 48'h1);
    // set and clear in one cycle: the set must win
    fork
      host.wr_blk(pmbid_pkg::CMD_CHIP_ID, 48'h0, 1);
      pulse(fault_clear);
    join
    chk(48'({cml_ivc_flag, status_cml_flag, alert_n}), 48'h6);
    // reset in mid-run drops flags, length and stores
    sys_rst = 1'b1;
    repeat (2) host.step();
    sys_rst = 1'b0;
    chk(48'({rd_len, cml_ivc_flag, status_cml_flag, alert_n}),
      48'h01);
    host.rd_blk(pmbid_pkg::CMD_SERIAL, q, n);
    chk(q, 48'h0);
    stop_test();
  end
endmodule : test_pmbus_identity_registers
`default_nettype wire
